// >>> hdl/irq_pkg.sv
/*
  Constants and types for the interrupt request and FPU error pin block.
  Assumes one 20 MHz core clock and an active-low asynchronous reset.
*/
// Functional notes
// R1: maskable request is active-high level, honoured only while enable flag set.
// R2: accepted maskable request runs an acknowledge cycle taking an 8-bit vector.
// R3: requester holds maskable request until the acknowledge cycle begins.
// R4: non-maskable request detected on rising edge, suspends instruction stream.
// R5: non-maskable request accepted whatever the enable flag says.
// R6: non-maskable vector is 2h internally, no external acknowledge cycle.
// R7: after non-maskable handling starts, further ones wait for interrupt return.
// R8: one rising edge during non-maskable handling is kept, serviced after return.
// R9: management request wins over non-maskable request.
// R10: management request saves state, then starts the management handler.
// R11: legacy mode: active-low management request is falling-edge, sampled every clock.
// R12: legacy mode: further management requests ignored until resume instruction.
// R13: legacy mode: one falling edge during servicing kept, done after resume.
// R14: enhanced mode: management request level sensitive, serviced while held.
// R15: error output driven low on an unmasked floating-point error.
// R16: error output asserted during the faulting floating-point instruction.
// R17: ignore-error asserted: pending errors disregarded, FP instructions continue.
// R18: no ignore and error pending: only the six no-wait FP instructions run.
// R19: native-error-reporting bit set: ignore-error input disregarded.
// R20: each asynchronous request input passes a two-flop synchroniser first.
package irq_pkg;
  localparam logic [7:0] NMI_VECTOR = 8'h02;
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam int SAVE_CYCLES = 4;
  localparam logic [2:0] SAVE_CNT_LAST = 3'(SAVE_CYCLES - 1);
  // floating-point instruction classes seen by the error gate
  localparam logic [2:0] FPC_OTHER = 3'h0;
  localparam logic [2:0] FPC_NCLEX = 3'h1;
  localparam logic [2:0] FPC_NINIT = 3'h2;
  localparam logic [2:0] FPC_NSAVE = 3'h3;
  localparam logic [2:0] FPC_NSTCW = 3'h4;
  localparam logic [2:0] FPC_NSTENV = 3'h5;
  localparam logic [2:0] FPC_NSTSW = 3'h6;
  typedef enum logic [2:0] {
    ST_RUN, ST_SAVE, ST_MGMT, ST_NMI_GO, ST_ACK, ST_INT_GO
  } core_state_e;
endpackage

// >>> hdl/sync2.sv
/*
  Two flip-flop level synchroniser.
  Assumes a single destination clock; first stage feeds only the second.
*/
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic d,
  output logic q
);
  logic meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d; // R20
      q <= meta_r;
    end
  end
endmodule // sync2
`default_nettype wire

// >>> hdl/irq_fpu_pins.sv
/*
  Interrupt request front end and FPU error handshake of the core.
  Assumes the core pipeline reports instruction events as one-cycle pulses
  and that the chipset drives the request pins asynchronously.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_fpu_pins
  import irq_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // request pins
  input wire logic MASKABLE_IRQ_IN,
  input wire logic NMI_IN,
  input wire logic SYS_MGMT_IRQ_N,
  // core state
  input wire logic IF_FLAG,
  input wire logic LEGACY_EDGE_MGMT_MODE,
  input wire logic INTERRUPT_RETURN_INSTR,
  input wire logic RESUME_FROM_MGMT_INSTR,
  // acknowledge cycle
  output logic ACK_CYCLE_REQ,
  input wire logic ACK_CYCLE_DONE,
  input wire logic [7:0] ACK_DATA,
  // core redirection
  output logic SUSPEND_STREAM,
  output logic VECTOR_VALID,
  output logic [7:0] VECTOR,
  output logic STATE_SAVE,
  output logic MGMT_ENTER,
  output logic IN_MGMT,
  output logic IN_NMI,
  // floating-point error
  input wire logic FP_ERROR_EVENT,
  input wire logic FP_ERROR_CLEAR,
  input wire logic FP_ISSUE,
  input wire logic [2:0] FP_CLASS,
  input wire logic NATIVE_ERROR_REPORT_BIT,
  input wire logic IGNORE_FP_ERROR_N,
  output logic FP_ERROR_STATUS_N,
  output logic FP_ISSUE_OK,
  output logic FP_ERROR_TRAP
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic mirq_s, nmi_s, mgmt_n_s, ign_n_s;

  sync2 #(.RST_VAL(1'b0)) u_sync_mirq (
    .clk(MCLK), .rst_n(RESETN), .d(MASKABLE_IRQ_IN), .q(mirq_s)); // R20
  sync2 #(.RST_VAL(1'b0)) u_sync_nmi (
    .clk(MCLK), .rst_n(RESETN), .d(NMI_IN), .q(nmi_s)); // R20
  sync2 #(.RST_VAL(1'b1)) u_sync_mgmt (
    .clk(MCLK), .rst_n(RESETN), .d(SYS_MGMT_IRQ_N), .q(mgmt_n_s)); // R20
  sync2 #(.RST_VAL(1'b1)) u_sync_ign (
    .clk(MCLK), .rst_n(RESETN), .d(IGNORE_FP_ERROR_N), .q(ign_n_s)); // R20

  // ************************************************************
  // edge detection and pending latches
  // ************************************************************
  logic nmi_d_r, mgmt_n_d_r;
  logic nmi_pend_r, mgmt_pend_r;
  logic nmi_edge, mgmt_fall;
  core_state_e state_r;
  logic nmi_blk_r, mgmt_blk_r;
  logic take_mgmt, take_nmi, take_int;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      nmi_d_r <= 1'b0;
      mgmt_n_d_r <= 1'b1;
    end else begin
      nmi_d_r <= nmi_s;
      mgmt_n_d_r <= mgmt_n_s; // R11
    end
  end

  assign nmi_edge = nmi_s & ~nmi_d_r; // R4
  assign mgmt_fall = ~mgmt_n_s & mgmt_n_d_r; // R11

  // one-deep store; a new edge wins over the take of the old one
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_r <= 1'b1; // R8
    end else if (take_nmi) begin
      nmi_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      mgmt_pend_r <= 1'b0;
    end else if (!LEGACY_EDGE_MGMT_MODE) begin
      mgmt_pend_r <= 1'b0;
    end else if (mgmt_fall) begin
      mgmt_pend_r <= 1'b1; // R13
    end else if (take_mgmt) begin
      mgmt_pend_r <= 1'b0;
    end
  end

  // ************************************************************
  // arbitration: management over non-maskable over maskable
  // ************************************************************
  logic mgmt_req;
  assign mgmt_req = LEGACY_EDGE_MGMT_MODE ? mgmt_pend_r : ~mgmt_n_s; // R11 R14
  // state is not redirected while inside management mode
  assign take_mgmt = (state_r == ST_RUN) && mgmt_req && !mgmt_blk_r; // R9 R12
  assign take_nmi = (state_r == ST_RUN) && !take_mgmt && nmi_pend_r
                    && !nmi_blk_r && !mgmt_blk_r; // R5 R7 R9
  assign take_int = (state_r == ST_RUN) && !take_mgmt && !take_nmi
                    && mirq_s && IF_FLAG && !mgmt_blk_r && !nmi_blk_r; // R1

  logic [2:0] save_cnt_r;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= ST_RUN;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (take_mgmt) begin
            state_r <= ST_SAVE; // R10
          end else if (take_nmi) begin
            state_r <= ST_NMI_GO; // R6
          end else if (take_int) begin
            state_r <= ST_ACK; // R2
          end
        end
        ST_SAVE: begin
          if (save_cnt_r == SAVE_CNT_LAST) begin
            state_r <= ST_MGMT;
          end
        end
        ST_MGMT: state_r <= ST_RUN;
        ST_NMI_GO: state_r <= ST_RUN;
        ST_ACK: begin
          if (ACK_CYCLE_DONE) begin
            state_r <= ST_INT_GO; // R2
          end
        end
        ST_INT_GO: state_r <= ST_RUN;
        default: state_r <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      save_cnt_r <= 3'h0;
    end else if (state_r == ST_SAVE) begin
      save_cnt_r <= save_cnt_r + 3'h1;
    end else begin
      save_cnt_r <= 3'h0;
    end
  end

  // handler blocking flags
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      nmi_blk_r <= 1'b0;
    end else if (take_nmi) begin
      nmi_blk_r <= 1'b1; // R7
    end else if (INTERRUPT_RETURN_INSTR) begin
      nmi_blk_r <= 1'b0; // R8
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      mgmt_blk_r <= 1'b0;
    end else if (take_mgmt) begin
      mgmt_blk_r <= 1'b1; // R12
    end else if (RESUME_FROM_MGMT_INSTR) begin
      mgmt_blk_r <= 1'b0; // R13
    end
  end

  // ************************************************************
  // core-facing outputs
  // ************************************************************
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ACK_CYCLE_REQ <= 1'b0;
      SUSPEND_STREAM <= 1'b0;
      VECTOR_VALID <= 1'b0;
      VECTOR <= 8'h00;
      STATE_SAVE <= 1'b0;
      MGMT_ENTER <= 1'b0;
      IN_MGMT <= 1'b0;
      IN_NMI <= 1'b0;
    end else begin
      ACK_CYCLE_REQ <= (take_int || state_r == ST_ACK) && !ACK_CYCLE_DONE; // R2
      SUSPEND_STREAM <= take_mgmt || take_nmi || take_int; // R4
      STATE_SAVE <= take_mgmt || (state_r == ST_SAVE &&
                    save_cnt_r != SAVE_CNT_LAST); // R10
      MGMT_ENTER <= state_r == ST_SAVE && save_cnt_r == SAVE_CNT_LAST; // R10
      IN_MGMT <= take_mgmt ? 1'b1 : (mgmt_blk_r && !RESUME_FROM_MGMT_INSTR);
      IN_NMI <= take_nmi ? 1'b1 : (nmi_blk_r && !INTERRUPT_RETURN_INSTR);
      VECTOR_VALID <= 1'b0;
      if (take_nmi) begin
        VECTOR_VALID <= 1'b1;
        VECTOR <= NMI_VECTOR; // R6
      end else if (state_r == ST_ACK && ACK_CYCLE_DONE) begin
        VECTOR_VALID <= 1'b1;
        VECTOR <= ACK_DATA; // R2
      end
    end
  end

  // ************************************************************
  // floating-point error handshake
  // ************************************************************
  logic fp_pend_r;
  logic ignore_eff, nowait_op, issue_ok;

  // an error raised in the clear cycle stays pending
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      fp_pend_r <= 1'b0;
    end else if (FP_ERROR_EVENT) begin
      fp_pend_r <= 1'b1; // R15
    end else if (FP_ERROR_CLEAR) begin
      fp_pend_r <= 1'b0;
    end
  end

  assign ignore_eff = !NATIVE_ERROR_REPORT_BIT && !ign_n_s; // R17 R19
  assign nowait_op = FP_CLASS == FPC_NCLEX || FP_CLASS == FPC_NINIT
                  || FP_CLASS == FPC_NSAVE || FP_CLASS == FPC_NSTCW
                  || FP_CLASS == FPC_NSTENV || FP_CLASS == FPC_NSTSW; // R18
  assign issue_ok = !fp_pend_r || ignore_eff || nowait_op; // R17 R18

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      FP_ERROR_STATUS_N <= 1'b1;
      FP_ISSUE_OK <= 1'b1;
      FP_ERROR_TRAP <= 1'b0;
    end else begin
      // low from the faulting instruction until cleared
      FP_ERROR_STATUS_N <= !(FP_ERROR_EVENT || fp_pend_r) ||
                           (FP_ERROR_CLEAR && !FP_ERROR_EVENT); // R15 R16
      // look one cycle ahead so the flag never lags the pending error
      FP_ISSUE_OK <= (issue_ok || (FP_ERROR_CLEAR && !FP_ERROR_EVENT)) &&
                     (!FP_ERROR_EVENT || ignore_eff || nowait_op); // R18
      FP_ERROR_TRAP <= FP_ISSUE && !issue_ok; // R18
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  AST_NMI_VEC: assert property (@(posedge MCLK) disable iff (!RESETN) // R6
    take_nmi |=> VECTOR_VALID && VECTOR == NMI_VECTOR && !ACK_CYCLE_REQ)
    else $error("nmi vector not 2h or ack issued");
  AST_NMI_BLOCK: assert property (@(posedge MCLK) disable iff (!RESETN) // R7
    nmi_blk_r && !INTERRUPT_RETURN_INSTR |-> !take_nmi)
    else $error("nmi taken while blocked");
  AST_NMI_KEEP: assert property (@(posedge MCLK) disable iff (!RESETN) // R8
    nmi_edge |=> nmi_pend_r)
    else $error("nmi edge lost");
  AST_NMI_UNMASK: assert property (@(posedge MCLK) disable iff (!RESETN) // R5
    state_r == ST_RUN && nmi_pend_r && !nmi_blk_r && !mgmt_blk_r && !mgmt_req
    |-> take_nmi)
    else $error("nmi not taken");
  AST_MGMT_PRIO: assert property (@(posedge MCLK) disable iff (!RESETN) // R9
    take_mgmt |-> !take_nmi && !take_int)
    else $error("mgmt lost priority");
  AST_MGMT_SAVE: assert property (@(posedge MCLK) disable iff (!RESETN) // R10
    take_mgmt |=> STATE_SAVE [*4] ##1 MGMT_ENTER)
    else $error("save then enter order broken");
  AST_MGMT_BLOCK: assert property (@(posedge MCLK) disable iff (!RESETN) // R12
    mgmt_blk_r |-> !take_mgmt)
    else $error("mgmt taken while servicing");
  AST_MIRQ_MASK: assert property (@(posedge MCLK) disable iff (!RESETN) // R1
    !IF_FLAG |-> !take_int)
    else $error("masked request taken");
  AST_FP_STATUS: assert property (@(posedge MCLK) disable iff (!RESETN) // R15
    FP_ERROR_EVENT |=> !FP_ERROR_STATUS_N)
    else $error("error output not asserted");
  AST_FP_GATE: assert property (@(posedge MCLK) disable iff (!RESETN) // R18
    fp_pend_r && !FP_ERROR_EVENT && !FP_ERROR_CLEAR && FP_ISSUE
    && FP_CLASS == FPC_OTHER && (NATIVE_ERROR_REPORT_BIT || ign_n_s)
    |=> FP_ERROR_TRAP)
    else $error("fp instruction ran with pending error");

  // ************************************************************
  // handshake and handler checks
  // ************************************************************
  AST_INT_ACK: assert property (@(posedge MCLK) disable iff (!RESETN) // R2
    take_int |=> ACK_CYCLE_REQ)
    else $error("no acknowledge cycle after take");
  AST_INT_VEC: assert property (@(posedge MCLK) disable iff (!RESETN) // R2
    state_r == ST_ACK && ACK_CYCLE_DONE
    |=> VECTOR_VALID && VECTOR == $past(ACK_DATA))
    else $error("vector not taken from bus");
  AST_ACK_DROP: assert property (@(posedge MCLK) disable iff (!RESETN) // R2
    ACK_CYCLE_REQ && ACK_CYCLE_DONE |=> !ACK_CYCLE_REQ)
    else $error("acknowledge request held after done");
  AST_NMI_SUSP: assert property (@(posedge MCLK) disable iff (!RESETN) // R4
    take_nmi |=> SUSPEND_STREAM && IN_NMI)
    else $error("stream not suspended for nmi");
  AST_SUSPEND: assert property (@(posedge MCLK) disable iff (!RESETN) // R4
    take_mgmt || take_int |=> SUSPEND_STREAM)
    else $error("stream not suspended");
  AST_NMI_CLEAR: assert property (@(posedge MCLK) disable iff (!RESETN) // R7
    nmi_blk_r && INTERRUPT_RETURN_INSTR && !take_nmi |=> !nmi_blk_r)
    else $error("nmi block not lifted by return");
  AST_MIRQ_BLOCK: assert property (@(posedge MCLK) disable iff (!RESETN) // R1
    mgmt_blk_r || nmi_blk_r |-> !take_int)
    else $error("maskable taken inside handler");
  AST_MGMT_IN: assert property (@(posedge MCLK) disable iff (!RESETN) // R10
    take_mgmt |=> IN_MGMT)
    else $error("handler flag not raised");
  AST_MGMT_EDGE: assert property (@(posedge MCLK) disable iff (!RESETN) // R11
    LEGACY_EDGE_MGMT_MODE && mgmt_fall |=> mgmt_pend_r)
    else $error("mgmt falling edge lost");
  AST_MGMT_KEEP: assert property (@(posedge MCLK) disable iff (!RESETN) // R13
    LEGACY_EDGE_MGMT_MODE && mgmt_pend_r && !take_mgmt
    |=> mgmt_pend_r || !LEGACY_EDGE_MGMT_MODE)
    else $error("stored mgmt edge dropped");
  AST_MGMT_LEVEL: assert property (@(posedge MCLK) disable iff (!RESETN) // R14
    state_r == ST_RUN && !LEGACY_EDGE_MGMT_MODE && !mgmt_n_s && !mgmt_blk_r
    |-> take_mgmt)
    else $error("held mgmt level not serviced");
  AST_FP_HOLD: assert property (@(posedge MCLK) disable iff (!RESETN) // R15
    fp_pend_r && !FP_ERROR_CLEAR |=> !FP_ERROR_STATUS_N)
    else $error("error output released while pending");
  AST_FP_IGNORE: assert property (@(posedge MCLK) disable iff (!RESETN) // R17
    ignore_eff && FP_ISSUE |=> !FP_ERROR_TRAP)
    else $error("trap while error ignored");
  AST_FP_NOWAIT: assert property (@(posedge MCLK) disable iff (!RESETN) // R18
    nowait_op && FP_ISSUE |=> !FP_ERROR_TRAP)
    else $error("no-wait op trapped");
  AST_FP_ISSUE: assert property (@(posedge MCLK) disable iff (!RESETN) // R18
    FP_ERROR_EVENT && !ignore_eff && !nowait_op |=> !FP_ISSUE_OK)
    else $error("issue flag lags the error");
  AST_FP_NATIVE: assert property (@(posedge MCLK) disable iff (!RESETN) // R19
    NATIVE_ERROR_REPORT_BIT |-> !ignore_eff)
    else $error("ignore input honoured in native mode");
endmodule // irq_fpu_pins
`default_nettype wire

// >>> verification/chipset_model.sv
/*
  Behavioural chipset model: maskable request source and acknowledge
  responder. Assumes the block raises its acknowledge request level and
  samples done and vector on the rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module chipset_model #(
  parameter logic [7:0] VEC = 8'h5a
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench control
  input wire logic raise,
  input wire logic [3:0] wait_cycles,
  // pins toward the block
  output logic irq,
  input wire logic ack_req,
  output logic ack_done,
  output logic [7:0] ack_data
);
  logic served;
  logic [3:0] cnt;

  // driven on the falling edge so the block samples settled values
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
      ack_done <= 1'b0;
      served <= 1'b0;
      cnt <= 4'h0;
    end else begin
      ack_done <= 1'b0;
      if (ack_req)
        irq <= 1'b0;
      else if (raise)
        irq <= 1'b1;
      if (!ack_req) begin
        served <= 1'b0;
        cnt <= 4'h0;
      end else if (!served && cnt == wait_cycles) begin
        ack_done <= 1'b1;
        served <= 1'b1;
      end else if (!served)
        cnt <= cnt + 4'h1;
    end
  end

  // bus holds junk outside the done strobe, never the vector itself
  assign ack_data = ack_done ? VEC : ~VEC;
endmodule // chipset_model
`default_nettype wire

// >>> verification/tb_top.sv
/*
  Self-checking bench for the interrupt and FPU error pin block.
  Assumes the chipset model on the far side answers acknowledge cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import irq_pkg::*;
;
  localparam logic [7:0] INT_VEC = 8'h5a;
  logic mclk, resetn, nmi, mg_n, if_flag, legacy, ret_ev, res_ev, mirq, raise;
  logic ack_req, ack_done, susp, vv, ssave, mg_enter, in_mg, in_nmi;
  logic fp_ev, fp_clr, fp_iss, native, ign_n, st_n, iss_ok, trap;
  logic [7:0] ack_data, vector;
  logic [2:0] fp_class;
  logic [3:0] slow;
  int failures = 0, num_checks = 0, vv_cnt = 0, mg_cnt = 0;
  int save_cnt = 0, trap_cnt = 0, ack_cnt = 0, susp_cnt = 0;

  irq_fpu_pins uut (.MCLK(mclk), .RESETN(resetn), .MASKABLE_IRQ_IN(mirq),
    .NMI_IN(nmi), .SYS_MGMT_IRQ_N(mg_n), .IF_FLAG(if_flag),
    .LEGACY_EDGE_MGMT_MODE(legacy), .INTERRUPT_RETURN_INSTR(ret_ev),
    .RESUME_FROM_MGMT_INSTR(res_ev), .ACK_CYCLE_REQ(ack_req),
    .ACK_CYCLE_DONE(ack_done), .ACK_DATA(ack_data), .SUSPEND_STREAM(susp),
    .VECTOR_VALID(vv), .VECTOR(vector), .STATE_SAVE(ssave),
    .MGMT_ENTER(mg_enter), .IN_MGMT(in_mg), .IN_NMI(in_nmi),
    .FP_ERROR_EVENT(fp_ev), .FP_ERROR_CLEAR(fp_clr), .FP_ISSUE(fp_iss),
    .FP_CLASS(fp_class), .NATIVE_ERROR_REPORT_BIT(native),
    .IGNORE_FP_ERROR_N(ign_n), .FP_ERROR_STATUS_N(st_n),
    .FP_ISSUE_OK(iss_ok), .FP_ERROR_TRAP(trap));

  chipset_model #(.VEC(INT_VEC)) far_end (.clk(mclk), .rst_n(resetn),
    .raise(raise), .wait_cycles(slow), .irq(mirq), .ack_req(ack_req),
    .ack_done(ack_done), .ack_data(ack_data));

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // pulses and levels counted on the sampling edge, judged later
  always @(posedge mclk) begin
    if (vv === 1'b1) vv_cnt++;
    if (mg_enter === 1'b1) mg_cnt++;
    if (ssave === 1'b1) save_cnt++;
    if (trap === 1'b1) trap_cnt++;
    if (ack_req === 1'b1) ack_cnt++;
    if (susp === 1'b1) susp_cnt++;
  end

  // ************************************
  // helpers
  // ************************************
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic note(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    note(got === exp, msg);
  endtask
  task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp,
                         input string msg);
    note(got === exp, msg);
  endtask
  task automatic chk_cnt(input int got, input int exp, input string msg);
    note(got == exp, msg);
  endtask
  task automatic pulse_nmi;
    nmi = 1'b1;
    step(4);
    nmi = 1'b0;
    step(6);
  endtask
  task automatic ret_pulse(input bit mgmt);
    if (mgmt) res_ev = 1'b1;
    else ret_ev = 1'b1;
    step(1);
    ret_ev = 1'b0;
    res_ev = 1'b0;
    step(10);
  endtask
  task automatic raise_int(input logic [3:0] dly, input int wait_n);
    slow = dly;
    raise = 1'b1;
    // two falling edges so the model sees it whatever the event order
    step(2);
    raise = 1'b0;
    step(wait_n);
  endtask
  task automatic fp_issue(input logic [2:0] cls);
    fp_class = cls;
    fp_iss = 1'b1;
    step(1);
    fp_iss = 1'b0;
    step(3);
  endtask

  // ************************************
  // scenarios
  // ************************************
  task automatic t_nmi;
    pulse_nmi;
    chk_cnt(vv_cnt, 1, "nmi taken with flag clear");
    chk_vec(vector, NMI_VECTOR, "nmi vector");
    chk_cnt(ack_cnt, 0, "no acknowledge cycle for nmi");
    chk_bit(in_nmi, 1'b1, "nmi handler active");
    pulse_nmi;
    pulse_nmi;
    chk_cnt(vv_cnt, 1, "nmi blocked in handler");
    ret_pulse(1'b0);
    chk_cnt(vv_cnt, 2, "stored nmi served after return");
    ret_pulse(1'b0);
    chk_cnt(vv_cnt, 2, "only one edge stored");
    chk_bit(in_nmi, 1'b0, "nmi handler left");
  endtask
  task automatic t_int;
    raise_int(4'h0, 12);
    chk_cnt(ack_cnt, 0, "masked request ignored");
    if_flag = 1'b1;
    step(12);
    chk_cnt(vv_cnt, 3, "prompt acknowledge taken");
    chk_vec(vector, INT_VEC, "vector from data bus");
    chk_bit(mirq, 1'b0, "request dropped at acknowledge");
    raise_int(4'h5, 20);
    chk_cnt(vv_cnt, 4, "slow acknowledge taken");
    if_flag = 1'b0;
  endtask
  task automatic t_smi;
    legacy = 1'b1;
    mg_n = 1'b0;
    nmi = 1'b1;
    step(12);
    chk_cnt(save_cnt, SAVE_CYCLES, "state save length");
    chk_cnt(mg_cnt, 1, "falling edge enters handler");
    chk_cnt(vv_cnt, 4, "mgmt wins over nmi");
    chk_bit(in_mg, 1'b1, "mgmt handler active");
    mg_n = 1'b1;
    nmi = 1'b0;
    step(4);
    repeat (2) begin
      mg_n = 1'b0;
      step(4);
      mg_n = 1'b1;
      step(4);
    end
    chk_cnt(mg_cnt, 1, "mgmt ignored in handler");
    ret_pulse(1'b1);
    chk_cnt(mg_cnt, 2, "stored edge served first");
    ret_pulse(1'b1);
    chk_cnt(mg_cnt, 2, "only one edge stored");
    chk_cnt(vv_cnt, 5, "held nmi served after mgmt");
    ret_pulse(1'b0);
  endtask
  task automatic t_level;
    legacy = 1'b0;
    mg_n = 1'b0;
    step(12);
    chk_cnt(mg_cnt, 3, "level enters handler");
    ret_pulse(1'b1);
    chk_cnt(mg_cnt, 4, "held level re-enters");
    mg_n = 1'b1;
    step(4);
    ret_pulse(1'b1);
    chk_cnt(mg_cnt, 4, "released level rests");
    chk_bit(in_mg, 1'b0, "mgmt handler left");
  endtask
  task automatic t_fp;
    fp_ev = 1'b1;
    step(1);
    fp_ev = 1'b0;
    chk_bit(st_n, 1'b0, "error shown in faulting op");
    chk_bit(iss_ok, 1'b0, "issue gated by error");
    fp_issue(FPC_OTHER);
    chk_cnt(trap_cnt, 1, "plain op trapped");
    for (int c = 0; c < 6; c++) fp_issue(FPC_NCLEX + 3'(c));
    chk_cnt(trap_cnt, 1, "no-wait ops pass");
    ign_n = 1'b0;
    step(4);
    fp_issue(FPC_OTHER);
    chk_cnt(trap_cnt, 1, "error ignored");
    chk_bit(st_n, 1'b0, "error still pending");
    native = 1'b1;
    step(2);
    fp_issue(FPC_OTHER);
    chk_cnt(trap_cnt, 2, "ignore input disregarded");
    native = 1'b0;
    ign_n = 1'b1;
    fp_clr = 1'b1;
    step(1);
    fp_clr = 1'b0;
    step(1);
    chk_bit(st_n, 1'b1, "error cleared");
    fp_issue(FPC_OTHER);
    chk_cnt(trap_cnt, 2, "no trap after clear");
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // whole run is a few hundred cycles; generous margin
  initial begin
    #(50 * 3000);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up;
  end

  initial begin
    {nmi, if_flag, legacy, ret_ev, res_ev, raise} = '0;
    {fp_ev, fp_clr, fp_iss, native} = '0;
    mg_n = 1'b1;
    ign_n = 1'b1;
    fp_class = FPC_OTHER;
    slow = 4'h0;
    resetn = 1'b0;
    step(12);
    resetn = 1'b1;
    step(2);
    t_nmi;
    t_int;
    t_smi;
    t_level;
    t_fp;
    chk_cnt(susp_cnt, vv_cnt + mg_cnt, "one suspend per take");
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
